// file: rtl/vsacsr_pkg.sv
// Constants, offsets and field positions of the VME-side adapter register bank
// ==========================================================================
// Function
// - Read-modify-write sets start; DMA begins then
// - Held PCI requests forwarded once unblocked
// - Window decodes as four eight-byte groups
// - Byte and word access only, no longword
// - Loopback bits redirect window; DMA blocked
// - Command bit 7 clears sticky errors
// - Command bit 6 clears received doorbell
// - Command bit 5 drives outgoing doorbell
// - Command bit 4 blocks backplane interrupts
// - Command bit 2 blocks interrupts to PCI
// - Status bit 7: sticky fiber data error
// - Status bit 6: sticky remote bus error
// - Status bit 2: DMA and access timeouts
// - Status bit 1 while doorbell unacknowledged
// - Status bit 0 live; remote accesses fail
// - Modifier driven only in DMA cycles
// - DMA command bit 7 starts the DMA
// - DMA command bit 1 flags DMA finished
package vsacsr_pkg;
    // ==========================================================================
    // Timing
    localparam int unsigned CLK_MHZ = 250;
    localparam int unsigned DMA_TMO_US = 16000;
    localparam int unsigned REM_TMO_US = 30000;
    localparam int unsigned DMA_TMO_CYC = DMA_TMO_US * CLK_MHZ;
    localparam int unsigned REM_TMO_CYC = REM_TMO_US * CLK_MHZ;
    localparam int unsigned TMO_W = 24;
    // ==========================================================================
    // Window layout
    localparam logic [4:0] OFF_LOOPBACK = 5'h00;
    localparam logic [4:0] OFF_LCMD = 5'h01;
    localparam logic [4:0] OFF_LSTAT = 5'h03;
    localparam logic [4:0] OFF_DMA_AM = 5'h04;
    localparam logic [4:0] OFF_IRQ_VEC = 5'h07;
    localparam logic [4:0] OFF_DMA_CMD = 5'h10;
    localparam logic [1:0] GRP_LOCAL_NODE = 2'h0;
    localparam logic [1:0] GRP_REMOTE_NODE = 2'h1;
    localparam logic [1:0] GRP_LOCAL_DMA = 2'h2;
    localparam logic [1:0] GRP_REMOTE_DMA = 2'h3;
    // ==========================================================================
    // Field positions
    localparam int LB_LOCAL = 0;
    localparam int LB_REMOTE = 1;
    localparam int CMD_CLR_ERR = 7;
    localparam int CMD_CLR_RX = 6;
    localparam int CMD_SEND_TX = 5;
    localparam int CMD_BLOCK_VME = 4;
    localparam int CMD_BLOCK_PCI = 2;
    localparam int DC_START = 7;
    localparam int DC_DONE = 1;
    // ==========================================================================
    // Reset values and masks
    localparam logic [1:0] LOOPBACK_RST = 2'h0;
    localparam logic [7:0] LCMD_RST = 8'h00;
    localparam logic [7:0] LCMD_RW_MASK = 8'h34;
    localparam logic [7:0] AM_RST = 8'h00;
    localparam logic [7:0] IRQ_VEC_RST = 8'hff;
    localparam logic [7:0] DMA_OPT_RST = 8'h00;
    localparam logic [7:0] DMA_OPT_MASK = 8'h3d;
    // Synchronised pin order
    localparam int NSYNC = 5;
    localparam int SI_FIBER = 0;
    localparam int SI_BUSERR = 1;
    localparam int SI_RX = 2;
    localparam int SI_ACK = 3;
    localparam int SI_OFF = 4;
endpackage

// file: rtl/vsacsr_tmo_if.sv
// Run and expiry pair between the register bank and a timeout counter
`timescale 1ns/1ps
interface vsacsr_tmo_if;
    logic run;
    logic expired;
    modport ctl (output run, input expired);
    modport tmr (input run, output expired);
endinterface // vsacsr_tmo_if

// file: rtl/vsacsr_sync2.sv
// Two-stage synchroniser for pin levels from outside the board clock
`timescale 1ns/1ps
module vsacsr_sync2 import vsacsr_pkg::*; #(
    parameter int W = NSYNC
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic resetn_in,
    // Levels
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_ff @(posedge clk_in) begin
                if (!resetn_in) begin
                    meta_q[i] <= 1'b0;
                    sync_q[i] <= 1'b0;
                end else begin
                    meta_q[i] <= async_in[i];
                    sync_q[i] <= meta_q[i];
                end
            end
        end
    endgenerate

    assign sync_out = sync_q;
endmodule // vsacsr_sync2

// file: rtl/vsacsr_timeout.sv
// Timeout counter: one pulse after LIMIT cycles of continuous run
`timescale 1ns/1ps
module vsacsr_timeout import vsacsr_pkg::*; #(
    parameter int unsigned LIMIT = DMA_TMO_CYC
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic resetn_in,
    // Control
    vsacsr_tmo_if.tmr tmo
);
    localparam logic [TMO_W-1:0] LAST = TMO_W'(LIMIT - 1);
    logic [TMO_W-1:0] cnt_q;
    logic hit_q;
    logic expired_q;

    // Saturates after firing so one stuck run gives one pulse
    always_ff @(posedge clk_in) begin
        if (!resetn_in || !tmo.run) begin
            cnt_q <= '0;
            hit_q <= 1'b0;
            expired_q <= 1'b0;
        end else begin
            expired_q <= (cnt_q == LAST) && !hit_q;
            if (cnt_q == LAST) begin
                hit_q <= 1'b1;
            end else begin
                cnt_q <= cnt_q + 1'b1;
            end
        end
    end

    assign tmo.expired = expired_q;
endmodule // vsacsr_timeout

// file: rtl/vsacsr_top.sv
// VME-side local node register bank with DMA command control
`timescale 1ns/1ps
module vsacsr_top import vsacsr_pkg::*; #(
    parameter int unsigned DMA_TMO_CYCLES = DMA_TMO_CYC,
    parameter int unsigned REM_TMO_CYCLES = REM_TMO_CYC
) (
    // Clock and reset
    input wire logic MCLK_IN,
    input wire logic RESETN_IN,
    // I/O window access from the VME slave decoder
    input wire logic IO_RD_IN,
    input wire logic IO_WR_IN,
    input wire logic IO_WORD_IN,
    input wire logic IO_LONG_IN,
    input wire logic [4:0] IO_ADDR_IN,
    input wire logic [15:0] IO_WDATA_IN,
    output logic IO_ACK_OUT,
    output logic IO_ERR_OUT,
    output logic [15:0] IO_RDATA_OUT,
    // Accesses handed on to other register groups
    output logic FWD_REQ_OUT,
    output logic [1:0] FWD_GROUP_OUT,
    // Cable and remote event pins
    input wire logic FIBER_ERR_IN,
    input wire logic REMOTE_BUS_ERR_IN,
    input wire logic FROM_PCI_DOORBELL_IN,
    input wire logic TO_PCI_ACK_IN,
    input wire logic REMOTE_OFF_IN,
    output logic TO_PCI_DOORBELL_OUT,
    output logic FROM_PCI_DOORBELL_CLR_OUT,
    // DMA engine
    input wire logic DMA_FINISH_IN,
    input wire logic DMA_CYCLE_IN,
    input wire logic REMOTE_ACC_BUSY_IN,
    output logic DMA_START_OUT,
    output logic DMA_BUSY_OUT,
    output logic DMA_ABORT_OUT,
    output logic REMOTE_ACC_ABORT_OUT,
    output logic [7:0] DMA_OPTIONS_OUT,
    output logic [7:0] DMA_AM_OUT,
    output logic DMA_AM_EN_OUT,
    // Loopback and backplane interrupt
    output logic LOCAL_LOOPBACK_OUT,
    output logic REMOTE_LOOPBACK_OUT,
    output logic VME_IRQ_OUT,
    output logic [7:0] IRQ_VECTOR_OUT
);
    // ==========================================================================
    // Decode helpers
    function automatic logic hit(input logic [4:0] addr, input logic word,
                                 input logic [4:0] off);
        hit = word ? (addr[4:1] == off[4:1]) : (addr == off);
    endfunction

    // Big-endian word: even offset on the high lane
    function automatic logic [7:0] lane(input logic word, input logic [15:0] wd,
                                        input logic [4:0] off);
        lane = (word && !off[0]) ? wd[15:8] : wd[7:0];
    endfunction

    // ==========================================================================
    // State
    logic [1:0] lb_q;
    logic [7:0] lcmd_q;
    logic [7:0] am_q;
    logic [7:0] vec_q;
    logic [7:0] dopt_q;
    logic busy_q;
    logic done_q;
    logic fiber_q;
    logic buserr_q;
    logic tmo_q;
    logic rx_q;
    logic tx_q;
    logic door_q;
    logic door_prev_q;
    logic rxclr_q;
    logic start_q;
    logic irq_q;
    logic ack_q;
    logic err_q;
    logic fwd_q;
    logic [1:0] fwd_grp_q;
    logic [15:0] rdata_q;
    logic [NSYNC-1:0] pin_prev_q;
    logic [NSYNC-1:0] pin_s;

    vsacsr_tmo_if dma_tmo ();
    vsacsr_tmo_if rem_tmo ();

    vsacsr_sync2 #(.W(NSYNC)) u_sync (
        .clk_in(MCLK_IN),
        .resetn_in(RESETN_IN),
        .async_in({REMOTE_OFF_IN, TO_PCI_ACK_IN, FROM_PCI_DOORBELL_IN,
                   REMOTE_BUS_ERR_IN, FIBER_ERR_IN}),
        .sync_out(pin_s)
    );

    vsacsr_timeout #(.LIMIT(DMA_TMO_CYCLES)) u_dma_tmo (
        .clk_in(MCLK_IN),
        .resetn_in(RESETN_IN),
        .tmo(dma_tmo.tmr)
    );

    vsacsr_timeout #(.LIMIT(REM_TMO_CYCLES)) u_rem_tmo (
        .clk_in(MCLK_IN),
        .resetn_in(RESETN_IN),
        .tmo(rem_tmo.tmr)
    );

    assign dma_tmo.run = busy_q;
    assign rem_tmo.run = REMOTE_ACC_BUSY_IN;

    // ==========================================================================
    // Access decode
    wire io_req = IO_RD_IN || IO_WR_IN;
    wire [1:0] grp = IO_ADDR_IN[4:3];
    wire bad_size = IO_LONG_IN || (IO_WORD_IN && IO_ADDR_IN[0]);
    wire is_dcmd = hit(IO_ADDR_IN, IO_WORD_IN, OFF_DMA_CMD);
    wire is_local = (grp == GRP_LOCAL_NODE) || is_dcmd;
    wire remote_off = pin_s[SI_OFF];
    wire off_fail = remote_off && (grp == GRP_REMOTE_NODE || grp == GRP_REMOTE_DMA);
    wire local_ans = io_req && (is_local || bad_size || off_fail);
    wire fwd_go = io_req && !is_local && !bad_size && !off_fail;
    wire wr_ok = IO_WR_IN && is_local && !bad_size;

    wire wr_lb = wr_ok && hit(IO_ADDR_IN, IO_WORD_IN, OFF_LOOPBACK);
    wire wr_lcmd = wr_ok && hit(IO_ADDR_IN, IO_WORD_IN, OFF_LCMD);
    wire wr_am = wr_ok && hit(IO_ADDR_IN, IO_WORD_IN, OFF_DMA_AM);
    wire wr_vec = wr_ok && hit(IO_ADDR_IN, IO_WORD_IN, OFF_IRQ_VEC);
    wire wr_dcmd = wr_ok && is_dcmd;
    wire [7:0] d_lb = lane(IO_WORD_IN, IO_WDATA_IN, OFF_LOOPBACK);
    wire [7:0] d_lcmd = lane(IO_WORD_IN, IO_WDATA_IN, OFF_LCMD);
    wire [7:0] d_am = lane(IO_WORD_IN, IO_WDATA_IN, OFF_DMA_AM);
    wire [7:0] d_vec = lane(IO_WORD_IN, IO_WDATA_IN, OFF_IRQ_VEC);
    wire [7:0] d_dcmd = lane(IO_WORD_IN, IO_WDATA_IN, OFF_DMA_CMD);

    // Write-only command pulses
    wire clr_err = wr_lcmd && d_lcmd[CMD_CLR_ERR];
    wire clr_rx = wr_lcmd && d_lcmd[CMD_CLR_RX];

    // DMA start refused while running or in either loopback mode
    wire start_go = wr_dcmd && d_dcmd[DC_START] && !busy_q && (lb_q == 2'h0);
    wire done_clr = wr_dcmd && !d_dcmd[DC_DONE];
    wire dma_end = busy_q && (DMA_FINISH_IN || dma_tmo.expired);

    // ==========================================================================
    // Event edges from synchronised pins and from the registered outgoing doorbell
    wire rx_rise = pin_s[SI_RX] && !pin_prev_q[SI_RX];
    wire ack_rise = pin_s[SI_ACK] && !pin_prev_q[SI_ACK];
    wire tx_rise = door_q && !door_prev_q;

    // ==========================================================================
    // Read view
    wire [7:0] v_lcmd = lcmd_q & LCMD_RW_MASK;
    wire [7:0] v_stat = {fiber_q, buserr_q, rx_q, 2'b00, tmo_q, tx_q, remote_off};
    wire [7:0] v_dcmd = {busy_q, dopt_q[6:2], done_q, dopt_q[0]};

    function automatic logic [7:0] byte_at(input logic [4:0] off);
        if (off == OFF_LOOPBACK) begin
            byte_at = {6'h00, lb_q};
        end else if (off == OFF_LCMD) begin
            byte_at = v_lcmd;
        end else if (off == OFF_LSTAT) begin
            byte_at = v_stat;
        end else if (off == OFF_DMA_AM) begin
            byte_at = am_q;
        end else if (off == OFF_IRQ_VEC) begin
            byte_at = vec_q;
        end else if (off == OFF_DMA_CMD) begin
            byte_at = v_dcmd;
        end else begin
            byte_at = 8'h00;
        end
    endfunction

    wire [4:0] even_addr = {IO_ADDR_IN[4:1], 1'b0};
    wire [4:0] odd_addr = {IO_ADDR_IN[4:1], 1'b1};
    wire [15:0] rd_word = {byte_at(even_addr), byte_at(odd_addr)};
    wire [15:0] rd_byte = {8'h00, byte_at(IO_ADDR_IN)};
    wire [15:0] rd_d = (IO_RD_IN && is_local && !bad_size)
                       ? (IO_WORD_IN ? rd_word : rd_byte) : 16'h0000;

    // ==========================================================================
    // Bus answer
    always_ff @(posedge MCLK_IN) begin
        if (!RESETN_IN) begin
            ack_q <= 1'b0;
            err_q <= 1'b0;
            fwd_q <= 1'b0;
            fwd_grp_q <= GRP_LOCAL_NODE;
            rdata_q <= 16'h0000;
        end else begin
            ack_q <= local_ans;
            err_q <= local_ans && (bad_size || off_fail);
            fwd_q <= fwd_go;
            fwd_grp_q <= fwd_go ? grp : fwd_grp_q;
            rdata_q <= rd_d;
        end
    end

    // ==========================================================================
    // Software-written registers
    always_ff @(posedge MCLK_IN) begin
        if (!RESETN_IN) begin
            lb_q <= LOOPBACK_RST;
            lcmd_q <= LCMD_RST;
            am_q <= AM_RST;
            vec_q <= IRQ_VEC_RST;
            dopt_q <= DMA_OPT_RST;
        end else begin
            lb_q <= wr_lb ? d_lb[LB_REMOTE:LB_LOCAL] : lb_q;
            lcmd_q <= wr_lcmd ? (d_lcmd & LCMD_RW_MASK) : lcmd_q;
            am_q <= wr_am ? d_am : am_q;
            vec_q <= wr_vec ? d_vec : vec_q;
            // Options frozen while a transfer runs
            dopt_q <= (wr_dcmd && !busy_q) ? (d_dcmd & DMA_OPT_MASK) : dopt_q;
        end
    end

    // ==========================================================================
    // DMA control and sticky status
    always_ff @(posedge MCLK_IN) begin
        if (!RESETN_IN) begin
            busy_q <= 1'b0;
            done_q <= 1'b0;
            start_q <= 1'b0;
            fiber_q <= 1'b0;
            buserr_q <= 1'b0;
            tmo_q <= 1'b0;
            rx_q <= 1'b0;
            tx_q <= 1'b0;
            rxclr_q <= 1'b0;
            pin_prev_q <= '0;
        end else begin
            start_q <= start_go;
            busy_q <= start_go || (busy_q && !dma_end);
            // Finish wins over a same-cycle software clear
            done_q <= dma_end || (done_q && !start_go && !done_clr);
            // Hardware set wins over the clear-errors write
            fiber_q <= pin_s[SI_FIBER] || (fiber_q && !clr_err);
            buserr_q <= pin_s[SI_BUSERR] || (buserr_q && !clr_err);
            tmo_q <= dma_tmo.expired || rem_tmo.expired || (tmo_q && !clr_err);
            rx_q <= rx_rise || (rx_q && !clr_rx);
            tx_q <= tx_rise || (tx_q && !ack_rise);
            rxclr_q <= clr_rx;
            pin_prev_q <= pin_s;
        end
    end

    // ==========================================================================
    // Interrupt outputs
    wire tx_want = lcmd_q[CMD_SEND_TX] && !lcmd_q[CMD_BLOCK_PCI];
    wire vme_want = ((done_q && dopt_q[2]) || rx_q) && !lcmd_q[CMD_BLOCK_VME];

    // A request raised under the block stays in the command bit and goes out on unblock
    always_ff @(posedge MCLK_IN) begin
        if (!RESETN_IN) begin
            door_q <= 1'b0;
            door_prev_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            door_q <= tx_want;
            door_prev_q <= door_q;
            irq_q <= vme_want;
        end
    end

    // ==========================================================================
    // Outputs
    assign IO_ACK_OUT = ack_q;
    assign IO_ERR_OUT = err_q;
    assign IO_RDATA_OUT = rdata_q;
    assign FWD_REQ_OUT = fwd_q;
    assign FWD_GROUP_OUT = fwd_grp_q;
    assign TO_PCI_DOORBELL_OUT = door_q;
    assign FROM_PCI_DOORBELL_CLR_OUT = rxclr_q;
    assign DMA_START_OUT = start_q;
    assign DMA_BUSY_OUT = busy_q;
    assign DMA_ABORT_OUT = dma_tmo.expired;
    assign REMOTE_ACC_ABORT_OUT = rem_tmo.expired;
    assign DMA_OPTIONS_OUT = dopt_q;
    assign DMA_AM_OUT = DMA_CYCLE_IN ? am_q : 8'h00;
    assign DMA_AM_EN_OUT = DMA_CYCLE_IN;
    assign LOCAL_LOOPBACK_OUT = lb_q[LB_LOCAL];
    assign REMOTE_LOOPBACK_OUT = lb_q[LB_REMOTE];
    assign VME_IRQ_OUT = irq_q;
    assign IRQ_VECTOR_OUT = vec_q;
endmodule // vsacsr_top

// file: testbench/vsacsr_far_model.sv
// Far-side model: DMA engine finish and PCI doorbell acknowledge
`timescale 1ns/1ps
module vsacsr_far_model (
    // Clock
    input wire logic clk_in,
    // Controls
    input wire logic start_in,
    input wire logic [7:0] fin_dly_in,
    input wire logic doorbell_in,
    input wire logic ack_en_in,
    // Answers
    output logic finish_out = 1'b0,
    output logic ack_out = 1'b0
);
    logic run_q = 1'b0;
    logic [7:0] cnt_q = 8'h00;
    // ==========
    // Engine: a long delay lets the DMA timer fire first
    always @(posedge clk_in) begin
        finish_out <= 1'b0;
        if (start_in) begin
            run_q <= 1'b1;
            cnt_q <= fin_dly_in;
        end else if (run_q && cnt_q == 8'h00) begin
            run_q <= 1'b0;
            finish_out <= 1'b1;
        end else if (run_q) begin
            cnt_q <= cnt_q - 8'h01;
        end
        ack_out <= doorbell_in & ack_en_in;
    end
endmodule // vsacsr_far_model

// file: testbench/vsacsr_top_asserts.sv
// Port-level concurrent checks for the register bank
`timescale 1ns/1ps
module vsacsr_top_asserts (
    // Clock and reset
    input wire logic MCLK_IN,
    input wire logic RESETN_IN,
    // Access
    input wire logic IO_RD_IN,
    input wire logic IO_WR_IN,
    input wire logic IO_WORD_IN,
    input wire logic IO_LONG_IN,
    input wire logic [4:0] IO_ADDR_IN,
    input wire logic [15:0] IO_WDATA_IN,
    input wire logic IO_ACK_OUT,
    input wire logic IO_ERR_OUT,
    input wire logic [15:0] IO_RDATA_OUT,
    input wire logic FWD_REQ_OUT,
    input wire logic [1:0] FWD_GROUP_OUT,
    // Events and DMA
    input wire logic TO_PCI_DOORBELL_OUT,
    input wire logic FROM_PCI_DOORBELL_CLR_OUT,
    input wire logic DMA_FINISH_IN,
    input wire logic DMA_CYCLE_IN,
    input wire logic DMA_START_OUT,
    input wire logic DMA_BUSY_OUT,
    input wire logic [7:0] DMA_AM_OUT,
    input wire logic LOCAL_LOOPBACK_OUT,
    input wire logic REMOTE_LOOPBACK_OUT,
    input wire logic VME_IRQ_OUT
);
    // ==========
    // Decode helpers
    wire logic acc = IO_RD_IN | IO_WR_IN;
    wire logic bw = IO_WR_IN & ~IO_WORD_IN & ~IO_LONG_IN;
    wire logic br = IO_RD_IN & ~IO_WORD_IN & ~IO_LONG_IN;
    default clocking @(posedge MCLK_IN); endclocking
    default disable iff (!RESETN_IN);
    // ==========
    // Properties
    property p_am; !DMA_CYCLE_IN |-> DMA_AM_OUT == 8'h00; endproperty
    a_am: assert property (p_am)
        else $error("modifier driven outside DMA cycle");
    property p_size;
        acc && (IO_LONG_IN || (IO_WORD_IN && IO_ADDR_IN[0]))
            |=> IO_ACK_OUT && IO_ERR_OUT && !FWD_REQ_OUT;
    endproperty
    a_size: assert property (p_size)
        else $error("bad access size not refused");
    property p_fwd;
        br && IO_ADDR_IN[4:3] == 2'h2 && IO_ADDR_IN[2:0] != 3'h0
            |=> FWD_REQ_OUT && FWD_GROUP_OUT == 2'h2 && !IO_ACK_OUT;
    endproperty
    a_fwd: assert property (p_fwd)
        else $error("DMA group access not forwarded");
    property p_rsv;
        br && IO_ADDR_IN == 5'h02 |=> IO_ACK_OUT && IO_RDATA_OUT == 16'h0000;
    endproperty
    a_rsv: assert property (p_rsv)
        else $error("reserved offset read nonzero");
    property p_dbell;
        bw && IO_ADDR_IN == 5'h01
            |-> ##2 TO_PCI_DOORBELL_OUT == ($past(IO_WDATA_IN[5], 2) & ~$past(IO_WDATA_IN[2], 2));
    endproperty
    a_dbell: assert property (p_dbell)
        else $error("outgoing doorbell wrong after command write");
    property p_clr;
        bw && IO_ADDR_IN == 5'h01 && IO_WDATA_IN[6] |=> FROM_PCI_DOORBELL_CLR_OUT;
    endproperty
    a_clr: assert property (p_clr)
        else $error("doorbell clear pulse missing");
    property p_blk; bw && IO_ADDR_IN == 5'h01 && IO_WDATA_IN[4] |-> ##2 !VME_IRQ_OUT; endproperty
    a_blk: assert property (p_blk)
        else $error("backplane interrupt not blocked");
    property p_start;
        bw && IO_ADDR_IN == 5'h10 && IO_WDATA_IN[7] && !DMA_BUSY_OUT
            && !LOCAL_LOOPBACK_OUT && !REMOTE_LOOPBACK_OUT |=> DMA_START_OUT && DMA_BUSY_OUT;
    endproperty
    a_start: assert property (p_start)
        else $error("start write did not start DMA");
    property p_lbk;
        bw && IO_ADDR_IN == 5'h10 && (LOCAL_LOOPBACK_OUT || REMOTE_LOOPBACK_OUT) |=> !DMA_START_OUT;
    endproperty
    a_lbk: assert property (p_lbk)
        else $error("DMA started in loopback");
    property p_fin; DMA_BUSY_OUT && DMA_FINISH_IN |=> !DMA_BUSY_OUT; endproperty
    a_fin: assert property (p_fin)
        else $error("DMA still busy after finish");
endmodule // vsacsr_top_asserts

bind vsacsr_top vsacsr_top_asserts vsacsr_top_asserts_i (.MCLK_IN, .RESETN_IN, .IO_RD_IN,
    .IO_WR_IN, .IO_WORD_IN, .IO_LONG_IN, .IO_ADDR_IN, .IO_WDATA_IN, .IO_ACK_OUT, .IO_ERR_OUT,
    .IO_RDATA_OUT, .FWD_REQ_OUT, .FWD_GROUP_OUT, .TO_PCI_DOORBELL_OUT,
    .FROM_PCI_DOORBELL_CLR_OUT, .DMA_FINISH_IN, .DMA_CYCLE_IN, .DMA_START_OUT, .DMA_BUSY_OUT,
    .DMA_AM_OUT, .LOCAL_LOOPBACK_OUT, .REMOTE_LOOPBACK_OUT, .VME_IRQ_OUT);

// file: testbench/vsacsr_top_test.sv
// Directed register-access bench for the register bank
`timescale 1ns/1ps
module vsacsr_top_test;
    logic clk = 1'b0, rstn = 1'b0, rd = 1'b0, wr = 1'b0, wd = 1'b0, lg = 1'b0;
    logic [4:0] addr = 5'h00;
    logic [15:0] wdat = 16'h0000, rq, rdat;
    logic fib = 1'b0, berr = 1'b0, rxd = 1'b0, off = 1'b0, cyc = 1'b0, rbusy = 1'b0;
    logic aken = 1'b0;
    logic saw_abrt = 1'b0, saw_rabrt = 1'b0;
    logic [7:0] fdly = 8'h0a, opts, am, vec;
    logic ack, err, fwd, dbell, clr, fin, pack, start, busy, abrt, rabrt, amen, llb, rlb, irq;
    logic rk, re, rf, rs, rc;
    logic [1:0] grp;
    int n_fail = 0, total_checks = 0;
    always #2 clk = ~clk;
    // Abort outputs are one-cycle pulses, so latch them for later checks
    always @(negedge clk) {saw_abrt, saw_rabrt} <= {saw_abrt | abrt, saw_rabrt | rabrt};
    // ==========
    // Design and far side
    vsacsr_top #(.DMA_TMO_CYCLES(50), .REM_TMO_CYCLES(80)) vsacsr_top_i (
        .MCLK_IN(clk), .RESETN_IN(rstn), .IO_RD_IN(rd), .IO_WR_IN(wr), .IO_WORD_IN(wd),
        .IO_LONG_IN(lg), .IO_ADDR_IN(addr), .IO_WDATA_IN(wdat), .IO_ACK_OUT(ack),
        .IO_ERR_OUT(err), .IO_RDATA_OUT(rdat), .FWD_REQ_OUT(fwd), .FWD_GROUP_OUT(grp),
        .FIBER_ERR_IN(fib), .REMOTE_BUS_ERR_IN(berr), .FROM_PCI_DOORBELL_IN(rxd),
        .TO_PCI_ACK_IN(pack), .REMOTE_OFF_IN(off), .TO_PCI_DOORBELL_OUT(dbell),
        .FROM_PCI_DOORBELL_CLR_OUT(clr), .DMA_FINISH_IN(fin), .DMA_CYCLE_IN(cyc),
        .REMOTE_ACC_BUSY_IN(rbusy), .DMA_START_OUT(start), .DMA_BUSY_OUT(busy),
        .DMA_ABORT_OUT(abrt), .REMOTE_ACC_ABORT_OUT(rabrt), .DMA_OPTIONS_OUT(opts),
        .DMA_AM_OUT(am), .DMA_AM_EN_OUT(amen), .LOCAL_LOOPBACK_OUT(llb),
        .REMOTE_LOOPBACK_OUT(rlb), .VME_IRQ_OUT(irq), .IRQ_VECTOR_OUT(vec));
    vsacsr_far_model vsacsr_far_model_i (.clk_in(clk), .start_in(start), .fin_dly_in(fdly),
        .doorbell_in(dbell), .ack_en_in(aken), .finish_out(fin), .ack_out(pack));
    // ==========
    // Access tasks
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic print_verdict();
        $display("checks=%0d mismatches=%0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // Strobe is a one-cycle pulse; the answer is captured one cycle later
    task automatic xfer(input logic w, input logic wx, input logic l, input logic [4:0] a,
            input logic [15:0] d);
        @(negedge clk);
        {rd, wr, wd, lg, addr, wdat} = {~w, w, wx, l, a, d};
        @(negedge clk);
        {rd, wr} = 2'b00;
        {rq, rk, re, rf, rs, rc} = {rdat, ack, err, fwd, start, clr};
    endtask
    task automatic wrb(input logic [4:0] a, input logic [7:0] d);
        xfer(1'b1, 1'b0, 1'b0, a, {8'h00, d});
    endtask
    task automatic rdb(input logic [4:0] a, input logic [7:0] e);
        xfer(1'b0, 1'b0, 1'b0, a, 16'h0000);
        chk(rq, {8'h00, e});
    endtask
    task automatic idle(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic wait_idle();
        int i;
        for (i = 0; i < 200 && busy !== 1'b0; i++) @(negedge clk);
        if (i == 200) begin
            n_fail++;
            print_verdict();
        end
    endtask
    // ==========
    // Scenarios
    initial begin
        idle(4);
        rstn = 1'b1;
        idle(2);
        for (int i = 0; i < 4; i++) begin
            xfer(1'b0, 1'b1, 1'b0, 5'(2 * i), 16'h0000);
            chk(rq, (i == 3) ? 16'h00ff : 16'h0000);
        end
        $display("test reset_values done");
        wrb(5'h04, 8'ha5);
        rdb(5'h04, 8'ha5);
        wrb(5'h02, 8'hff);
        rdb(5'h02, 8'h00);
        wrb(5'h03, 8'hff);
        rdb(5'h03, 8'h00);
        wrb(5'h00, 8'hff);
        rdb(5'h00, 8'h03);
        wrb(5'h10, 8'h80);
        chk({rs, busy, llb, rlb}, 16'h3);
        wrb(5'h00, 8'h00);
        $display("test loopback done");
        wrb(5'h01, 8'hff);
        chk(rc, 16'h1);
        idle(1);
        chk({dbell, irq}, 16'h0);
        rdb(5'h01, 8'h34);
        wrb(5'h01, 8'h20);
        idle(4);
        chk(dbell, 16'h1);
        rdb(5'h03, 8'h02);
        aken = 1'b1;
        idle(6);
        rdb(5'h03, 8'h00);
        aken = 1'b0;
        wrb(5'h01, 8'h00);
        idle(2);
        chk(dbell, 16'h0);
        $display("test doorbell done");
        wrb(5'h10, 8'h04);
        chk(opts, 16'h4);
        wrb(5'h11, 8'h40);
        chk({rf, grp}, 16'h6);
        wrb(5'h18, 8'h40);
        chk({rf, grp}, 16'h7);
        wrb(5'h1f, 8'h01);
        chk({rf, grp}, 16'h7);
        wrb(5'h01, 8'h04);
        rdb(5'h10, 8'h04);
        wrb(5'h10, rq[7:0] | 8'h80);
        chk({rs, busy}, 16'h3);
        rdb(5'h10, 8'h84);
        cyc = 1'b1;
        idle(1);
        chk({amen, am}, 16'h1a5);
        cyc = 1'b0;
        idle(1);
        chk(am, 16'h0);
        wait_idle();
        rdb(5'h10, 8'h06);
        idle(2);
        chk(irq, 16'h1);
        wrb(5'h01, 8'h10);
        idle(2);
        chk(irq, 16'h0);
        wrb(5'h01, 8'h00);
        wrb(5'h10, 8'h04);
        idle(2);
        chk(irq, 16'h0);
        $display("test dma done");
        fdly = 8'hff;
        wrb(5'h10, 8'h84);
        wait_idle();
        rdb(5'h03, 8'h04);
        chk({saw_abrt, saw_rabrt}, 16'h2);
        rdb(5'h10, 8'h06);
        wrb(5'h01, 8'h80);
        rdb(5'h03, 8'h00);
        rbusy = 1'b1;
        idle(90);
        rbusy = 1'b0;
        rdb(5'h03, 8'h04);
        chk({saw_abrt, saw_rabrt}, 16'h3);
        wrb(5'h01, 8'h80);
        wrb(5'h10, 8'h00);
        $display("test timeouts done");
        {fib, berr} = 2'b11;
        idle(3);
        {fib, berr} = 2'b00;
        idle(8);
        rdb(5'h03, 8'hc0);
        wrb(5'h01, 8'h80);
        rdb(5'h03, 8'h00);
        rxd = 1'b1;
        idle(5);
        rdb(5'h03, 8'h20);
        chk(irq, 16'h1);
        wrb(5'h01, 8'h40);
        rdb(5'h03, 8'h00);
        chk(irq, 16'h0);
        rxd = 1'b0;
        $display("test status done");
        for (int g = 1; g < 4; g++) begin
            xfer(1'b0, 1'b0, 1'b0, {g[1:0], 3'h2}, 16'h0000);
            chk({rk, rf, 12'h000, grp}, {2'b01, 12'h000, g[1:0]});
        end
        xfer(1'b1, 1'b0, 1'b1, 5'h04, 16'hffff);
        chk({rk, re, rf}, 16'h6);
        xfer(1'b0, 1'b1, 1'b0, 5'h01, 16'h0000);
        chk({rk, re, rf}, 16'h6);
        rdb(5'h04, 8'ha5);
        wrb(5'h07, 8'h3c);
        chk(vec, 16'h003c);
        off = 1'b1;
        idle(5);
        rdb(5'h03, 8'h01);
        xfer(1'b0, 1'b0, 1'b0, 5'h09, 16'h0000);
        chk({rk, re, rf}, 16'h6);
        off = 1'b0;
        $display("test window done");
        print_verdict();
    end
endmodule // vsacsr_top_test
